/* shared/timebase_pkg.sv */
// Constants for the up/down time-base unit: register offsets, field
// positions, reset values and widths.
// Assumes a plain register port with byte addresses and 32-bit data.
package timebase_pkg;

  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFF_STATUS_FLAGS = 8'h04;
  localparam logic [7:0] OFF_EVENT_GENERATION = 8'h08;
  localparam logic [7:0] OFF_COUNT_VALUE = 8'h0c;
  localparam logic [7:0] OFF_PRESCALE_DIVIDER = 8'h10;
  localparam logic [7:0] OFF_RELOAD_LIMIT = 8'h14;
  localparam logic [7:0] OFF_REPEAT_COUNT = 8'h18;

  // Field positions in control_one.
  localparam int BIT_COUNT_ENABLE = 0;
  localparam int BIT_UPDATE_DISABLE = 1;
  localparam int BIT_UPDATE_SOURCE_SELECT = 2;
  localparam int BIT_RELOAD_PRELOAD_EN = 3;
  localparam int BIT_COUNT_DOWN = 4;

  // Field positions in status_flags and event_generation.
  localparam int BIT_UPDATE_FLAG = 0;
  localparam int BIT_UPDATE_GENERATE = 0;

  // Default widths of the counter and repetition counter, and the fixed prescaler width.
  localparam int COUNT_W_DEF = 16;
  localparam int PRESCALE_W = 16;
  localparam int REPEAT_W_DEF = 8;

  // Reset values.
  localparam logic [15:0] RESET_PRESCALE = 16'h0000;
  localparam logic [31:0] RESET_RELOAD = 32'hffff_ffff;
  localparam logic [31:0] RESET_COUNT = 32'h0000_0000;
  localparam logic [7:0] RESET_REPEAT = 8'h00;

endpackage

/* src/timebase_unit.sv */
// Time-base unit: prescaler, up/down counter, preloaded reload limit,
// repetition counter and update event generation behind a register port.
// Assumes a single 10 MHz clock and a master that keeps strobes one
// cycle long and never raises write and read together.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module timebase_unit
  import timebase_pkg::*;
#(
  parameter int COUNT_W = COUNT_W_DEF,
  parameter int REPEAT_W = REPEAT_W_DEF
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_reset,
  // Register port.
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [DATA_W-1:0] o_rdata,
  // Time-base state seen by the rest of the timer.
  output logic [COUNT_W-1:0] o_count_value,
  output logic o_update_event,
  output logic o_update_flag
);

  // Whole state of the block, registered as one word.
  typedef struct packed {
    logic count_enable;
    logic update_disable;
    logic update_source_select;
    logic reload_preload_en;
    logic count_down;
    logic update_flag;
    logic [COUNT_W-1:0] count_value;
    logic [PRESCALE_W-1:0] prescale_divider;
    logic [PRESCALE_W-1:0] prescale_buffer;
    logic [PRESCALE_W-1:0] prescale_count;
    logic [COUNT_W-1:0] reload_limit;
    logic [COUNT_W-1:0] reload_shadow;
    logic [REPEAT_W-1:0] repeat_count;
    logic [REPEAT_W-1:0] repeat_left;
    logic [DATA_W-1:0] rdata;
    logic update_event;
  } state_t;

  state_t s_r; // Registered state.
  state_t s_nxt; // Next state.

  // Decoded strobes and derived terms, visible to the assertions too.
  logic wr_control; // Write to control_one.
  logic wr_status; // Write to status_flags.
  logic wr_count; // Write to count_value.
  logic gen_write; // Software update request.
  logic tick; // One count_tick_clock pulse.
  logic wrap; // Overflow or underflow on this tick.
  logic hw_update; // Wrap that passes repetition and disable.
  logic update_nxt; // Any update event this cycle.
  logic [COUNT_W-1:0] reload_active; // Limit the counter compares with.
  logic [COUNT_W-1:0] reload_next; // Limit in force after this cycle.

  // Address decode for writes, kept apart so the assertions can see it.
  always_comb begin
    wr_control = i_write && (i_addr == OFF_CONTROL_ONE);
    wr_status = i_write && (i_addr == OFF_STATUS_FLAGS);
    wr_count = i_write && (i_addr == OFF_COUNT_VALUE);
    gen_write = i_write && (i_addr == OFF_EVENT_GENERATION) &&
                i_wdata[BIT_UPDATE_GENERATE];
  end

  // Prescaler tick, wrap detection and update qualification.
  always_comb begin
    // With preload off the shadow is bypassed, so a new limit acts at once.
    if (s_r.reload_preload_en) begin
      reload_active = s_r.reload_shadow;
    end else begin
      reload_active = s_r.reload_limit;
    end
    // The registered enable is used, so a write of count_enable only
    // takes effect on the following cycle.
    tick = s_r.count_enable &&
           (s_r.prescale_count == s_r.prescale_buffer);
    if (s_r.count_down) begin
      wrap = tick && (s_r.count_value == '0);
    end else begin
      wrap = tick && (s_r.count_value == reload_active);
    end
    // A repetition count of zero lets every wrap through while updates are enabled.
    hw_update = wrap && !s_r.update_disable &&
                (s_r.repeat_left == '0);
    update_nxt = hw_update || gen_write;
    // Down counting reloads with the freshly transferred limit.
    if (update_nxt) begin
      reload_next = s_r.reload_limit;
    end else begin
      reload_next = reload_active;
    end
  end

  // Next-state logic for counters, registers and the read port.
  always_comb begin
    s_nxt = s_r;
    s_nxt.update_event = update_nxt;

    // Prescaler counter: counts to the buffered ratio and restarts.
    if (gen_write || !s_r.count_enable) begin
      s_nxt.prescale_count = '0;
    end else if (tick) begin
      s_nxt.prescale_count = '0;
    end else begin
      s_nxt.prescale_count = s_r.prescale_count + 1'b1;
    end

    // Main counter. A software update restarts the period.
    if (gen_write) begin
      if (s_r.count_down) begin
        s_nxt.count_value = reload_next;
      end else begin
        s_nxt.count_value = '0;
      end
    end else if (wr_count) begin
      s_nxt.count_value = i_wdata[COUNT_W-1:0];
    end else if (wrap) begin
      // The wrap happens even when updates are disabled.
      if (s_r.count_down) begin
        s_nxt.count_value = reload_next;
      end else begin
        s_nxt.count_value = '0;
      end
    end else if (tick) begin
      if (s_r.count_down) begin
        s_nxt.count_value = s_r.count_value - 1'b1;
      end else begin
        s_nxt.count_value = s_r.count_value + 1'b1;
      end
    end

    // Repetition counter: reloaded on every update, else counts wraps while updates are enabled.
    if (update_nxt) begin
      s_nxt.repeat_left = s_r.repeat_count;
    end else if (wrap && !s_r.update_disable) begin
      s_nxt.repeat_left = s_r.repeat_left - 1'b1;
    end

    // Shadows move only on an update; the limit shadow also tracks when preload is off.
    if (update_nxt || !s_r.reload_preload_en) begin
      s_nxt.reload_shadow = s_r.reload_limit;
    end
    if (update_nxt) begin
      s_nxt.prescale_buffer = s_r.prescale_divider;
    end

    // Software writes to control and preload registers.
    if (wr_control) begin
      s_nxt.count_enable = i_wdata[BIT_COUNT_ENABLE];
      s_nxt.update_disable = i_wdata[BIT_UPDATE_DISABLE];
      s_nxt.update_source_select = i_wdata[BIT_UPDATE_SOURCE_SELECT];
      s_nxt.reload_preload_en = i_wdata[BIT_RELOAD_PRELOAD_EN];
      s_nxt.count_down = i_wdata[BIT_COUNT_DOWN];
    end
    if (i_write && (i_addr == OFF_PRESCALE_DIVIDER)) begin
      s_nxt.prescale_divider = i_wdata[PRESCALE_W-1:0];
    end
    if (i_write && (i_addr == OFF_RELOAD_LIMIT)) begin
      s_nxt.reload_limit = i_wdata[COUNT_W-1:0];
    end
    if (i_write && (i_addr == OFF_REPEAT_COUNT)) begin
      s_nxt.repeat_count = i_wdata[REPEAT_W-1:0];
    end

    // Update flag: written zero clears it, but a new event wins.
    if (hw_update ||
        (gen_write && !s_r.update_source_select)) begin
      s_nxt.update_flag = 1'b1;
    end else if (wr_status && !i_wdata[BIT_UPDATE_FLAG]) begin
      s_nxt.update_flag = 1'b0;
    end

    // Read data stands for exactly one cycle after the strobe.
    s_nxt.rdata = '0;
    if (i_read) begin
      if (i_addr == OFF_CONTROL_ONE) begin
        s_nxt.rdata[BIT_COUNT_ENABLE] = s_r.count_enable;
        s_nxt.rdata[BIT_UPDATE_DISABLE] = s_r.update_disable;
        s_nxt.rdata[BIT_UPDATE_SOURCE_SELECT] = s_r.update_source_select;
        s_nxt.rdata[BIT_RELOAD_PRELOAD_EN] = s_r.reload_preload_en;
        s_nxt.rdata[BIT_COUNT_DOWN] = s_r.count_down;
      end else if (i_addr == OFF_STATUS_FLAGS) begin
        s_nxt.rdata[BIT_UPDATE_FLAG] = s_r.update_flag;
      end else if (i_addr == OFF_COUNT_VALUE) begin
        s_nxt.rdata[COUNT_W-1:0] = s_r.count_value;
      end else if (i_addr == OFF_PRESCALE_DIVIDER) begin
        s_nxt.rdata[PRESCALE_W-1:0] = s_r.prescale_divider;
      end else if (i_addr == OFF_RELOAD_LIMIT) begin
        s_nxt.rdata[COUNT_W-1:0] = s_r.reload_limit;
      end else if (i_addr == OFF_REPEAT_COUNT) begin
        s_nxt.rdata[REPEAT_W-1:0] = s_r.repeat_count;
      end
      // The generate bit and unmapped addresses read as zero.
    end
  end

  // State register; the reset values are all constants.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      s_r <= '0;
      s_r.count_value <= RESET_COUNT[COUNT_W-1:0];
      s_r.prescale_divider <= RESET_PRESCALE;
      s_r.prescale_buffer <= RESET_PRESCALE;
      s_r.reload_limit <= RESET_RELOAD[COUNT_W-1:0];
      s_r.reload_shadow <= RESET_RELOAD[COUNT_W-1:0];
      s_r.repeat_count <= RESET_REPEAT[REPEAT_W-1:0];
      s_r.repeat_left <= RESET_REPEAT[REPEAT_W-1:0];
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign o_rdata = s_r.rdata;
  assign o_count_value = s_r.count_value;
  assign o_update_event = s_r.update_event;
  assign o_update_flag = s_r.update_flag;

  // A disabled counter holds unless software writes it or restarts it.
  hold_disabled_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (!s_r.count_enable && !wr_count && !gen_write)
      |=> $stable(o_count_value))
    else $error("Counter moved while disabled.");

  // The cycle that writes the enable does not yet count.
  start_delay_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (!s_r.count_enable && wr_control && i_wdata[BIT_COUNT_ENABLE] &&
     !wr_count && !gen_write)
      |=> $stable(o_count_value) && s_r.count_enable)
    else $error("Counter started in the enable write cycle.");

  // Up counting wraps from the active limit to zero.
  up_wrap_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (tick && !s_r.count_down && s_r.count_value == reload_active &&
     !wr_count)
      |=> (o_count_value == '0))
    else $error("Up counter did not wrap to zero.");

  // Down counting reloads the limit in force after the update.
  down_reload_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (tick && s_r.count_down && s_r.count_value == '0 && !wr_count &&
     !gen_write)
      |=> (o_count_value == $past(reload_next)))
    else $error("Down counter did not reload the limit.");

  // A software request gives one update pulse in the next cycle.
  sw_update_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    gen_write |=> o_update_event ##1 (o_update_event == $past(update_nxt)))
    else $error("Software update pulse missing or stretched.");

  // With updates disabled only software requests give an event.
  disable_block_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (s_r.update_disable && !gen_write) |=> !o_update_event)
    else $error("Update event while updates were disabled.");

  // With preload on, the shadow limit only moves on an update.
  shadow_hold_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (s_r.reload_preload_en && !update_nxt)
      |=> $stable(s_r.reload_shadow))
    else $error("Shadow limit changed without an update.");

  // The prescale buffer changes only at an update event.
  ratio_buffer_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !update_nxt |=> $stable(s_r.prescale_buffer))
    else $error("Prescale ratio changed between updates.");

  // A hidden software update leaves a clear flag clear.
  hidden_flag_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (gen_write && s_r.update_source_select && !s_r.update_flag &&
     !hw_update)
      |=> (o_update_event && !o_update_flag))
    else $error("Hidden software update set the flag.");

  // The prescaler counter never runs past the buffered ratio.
  prescale_bound_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    s_r.prescale_count <= s_r.prescale_buffer)
    else $error("Prescaler counter passed the ratio.");

  // A wrap with repetitions left gives no update event.
  repeat_gate_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (wrap && s_r.repeat_left != '0 && !gen_write) |=> !o_update_event)
    else $error("Update event before the repetitions ran out.");

  // An update reloads the repeat counter and the prescale buffer.
  update_reload_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    update_nxt |=> (s_r.repeat_left == $past(s_r.repeat_count) &&
                    s_r.prescale_buffer == $past(s_r.prescale_divider)))
    else $error("Update did not reload repeat count or ratio.");

  // Up mode with updates disabled still wraps and restarts the prescaler.
  up_disabled_wrap_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (wrap && !s_r.count_down && s_r.update_disable && !wr_count &&
     !gen_write)
      |=> (o_count_value == '0 && s_r.prescale_count == '0 &&
           $stable(s_r.prescale_buffer)))
    else $error("Disabled up wrap did not restart cleanly.");

  // Down mode with updates disabled restarts from the limit in use.
  down_disabled_wrap_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (wrap && s_r.count_down && s_r.update_disable && !wr_count &&
     !gen_write)
      |=> (o_count_value == $past(reload_active) &&
           s_r.prescale_count == '0 && $stable(s_r.prescale_buffer)))
    else $error("Disabled down wrap did not restart cleanly.");

  // A down update reloads the counter with the new preload limit.
  down_new_limit_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (hw_update && s_r.count_down && !wr_count && !gen_write)
      |=> (o_count_value == $past(s_r.reload_limit)))
    else $error("Down update reloaded a stale limit.");

  // The update generate bit always reads back as zero.
  gen_reads_zero_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_read && i_addr == OFF_EVENT_GENERATION) |=> (o_rdata == '0))
    else $error("Update generate bit read back as set.");

endmodule

/* dv/tb_top.sv */
// Self-checking bench for the up/down time-base unit.
// Assumes the unit with its default widths and the clock made here.
`timescale 1ns/1ps

module tb_top
  import timebase_pkg::*;
;
  // Register port and clock of the unit.
  logic i_clock;
  logic i_reset;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic i_write;
  logic i_read;
  logic [DATA_W-1:0] o_rdata;
  logic [COUNT_W_DEF-1:0] o_count_value;
  logic o_update_event;
  logic o_update_flag;
  // Bookkeeping of the run.
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  // Rows: mode, divider, limit, repeat, start, new limit, new divider, cycles.
  int tbl [6][8] = '{'{'h00, 0, 3, 0, 0, 3, 0, 12},
                     '{'h08, 0, 4, 1, 2, 2, 1, 30},
                     '{'h18, 1, 3, 0, 1, 5, 0, 30},
                     '{'h1a, 0, 3, 0, 2, 1, 1, 16},
                     '{'h02, 0, 2, 1, 1, 2, 1, 12},
                     '{'h10, 0, 2, 2, 0, 2, 0, 24}};
  // Reset values, indexed by word address; the last word is unmapped.
  logic [31:0] rst_val [8];

  timebase_unit timebase_unit_inst (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_write(i_write),
    .i_read(i_read),
    .o_rdata(o_rdata),
    .o_count_value(o_count_value),
    .o_update_event(o_update_event),
    .o_update_flag(o_update_flag)
  );

  // The clock runs at 10 MHz.
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // A hang is cut short well after the expected run of some 300 cycles.
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  // Counts the comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One write cycle; an idle cycle follows so the strobe never toggles twice.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
    @(posedge i_clock);
  endtask

  // One read cycle; the answer is taken at the edge closing its one cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string what);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    @(posedge i_clock);
    chk(what, exp, o_rdata);
  endtask

  // Steps a reference of counter, prescaler and repetition counter and
  // compares each cycle. Values seen at an edge are those of the cycle
  // before it, so the model is compared first and advanced after.
  task automatic run(input logic [4:0] m, input int n, input int c,
                     input int lim, input int nlim, input int dv,
                     input int ndv, input int rep);
    int pc;
    int rc;
    logic ev;
    logic tk;
    logic wrap;
    logic seen;
    pc = 0;
    rc = rep;
    ev = 1'b0;
    seen = 1'b0;
    repeat (n) begin
      chk("count_value", c, o_count_value);
      chk("update_event", ev, o_update_event);
      tk = (pc == dv);
      pc = tk ? 0 : pc + 1;
      wrap = tk && (m[4] ? c == 0 : c == lim);
      ev = wrap && !m[1] && rc == 0;
      // Wraps while updates are disabled leave the repetition count alone.
      if (wrap && !m[1]) begin
        rc = (rc == 0) ? rep : rc - 1;
      end
      // The new limit is active before a down count reloads from it.
      if (ev) begin
        lim = nlim;
        dv = ndv;
      end
      if (tk) begin
        c = wrap ? (m[4] ? lim : 0) : (m[4] ? c - 1 : c + 1);
      end
      seen = seen | ev;
      @(posedge i_clock);
    end
    chk("update_flag", seen, o_update_flag);
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: reset values, counting table, then software updates.
  initial begin
    i_reset = 1'b1;
    i_write = 1'b0;
    i_read = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    rst_val = '{default: 32'h0000_0000};
    rst_val[3] = RESET_COUNT & ((32'h0000_0001 << COUNT_W_DEF) - 1);
    rst_val[4] = {16'h0000, RESET_PRESCALE};
    rst_val[5] = RESET_RELOAD & ((32'h0000_0001 << COUNT_W_DEF) - 1);
    rst_val[6] = {24'h00_0000, RESET_REPEAT};
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    // Every register and one unmapped word read back their reset value.
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4), rst_val[i], "reset_value");
    end
    $display("test reset values done");
    // Each row loads its settings with an update while stopped, then
    // changes preload values so that buffered copies can be told apart.
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CONTROL_ONE, tbl[i][0] & 'h1d);
      wr(OFF_PRESCALE_DIVIDER, tbl[i][1]);
      wr(OFF_RELOAD_LIMIT, tbl[i][2]);
      wr(OFF_REPEAT_COUNT, tbl[i][3]);
      wr(OFF_EVENT_GENERATION, 1);
      wr(OFF_COUNT_VALUE, tbl[i][4]);
      wr(OFF_RELOAD_LIMIT, tbl[i][5]);
      wr(OFF_PRESCALE_DIVIDER, tbl[i][6]);
      wr(OFF_STATUS_FLAGS, 0);
      wr(OFF_CONTROL_ONE, tbl[i][0] | 1);
      run(5'(tbl[i][0]), tbl[i][7], tbl[i][4], tbl[i][2], tbl[i][5],
          tbl[i][1], tbl[i][6], tbl[i][3]);
      rd(OFF_RELOAD_LIMIT, tbl[i][5], "reload_limit");
      rd(OFF_PRESCALE_DIVIDER, tbl[i][6], "prescale_divider");
      $display("test counting row %0d done", i);
    end
    // A software update with the source select set pulses but hides.
    wr(OFF_CONTROL_ONE, 32'h0000_0004);
    wr(OFF_STATUS_FLAGS, 0);
    wr(OFF_EVENT_GENERATION, 1);
    chk("update_event", 1'b1, o_update_event);
    @(posedge i_clock);
    chk("update_event", 1'b0, o_update_event);
    chk("update_flag", 1'b0, o_update_flag);
    rd(OFF_EVENT_GENERATION, 0, "event_generation");
    // Without the source select the same request raises the flag.
    wr(OFF_CONTROL_ONE, 0);
    wr(OFF_EVENT_GENERATION, 1);
    chk("update_flag", 1'b1, o_update_flag);
    wr(OFF_STATUS_FLAGS, 1);
    chk("update_flag", 1'b1, o_update_flag);
    wr(OFF_STATUS_FLAGS, 0);
    chk("update_flag", 1'b0, o_update_flag);
    $display("test software update done");
    end_of_test();
  end
endmodule
